// ==== hdl/lrc_pkg.sv ====
package lrc_pkg;

   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam logic [7:0] LRC_CTRL_OFFS   = 8'h00;
   localparam logic [7:0] LRC_STATUS_OFFS = 8'h04;

   // control register fields
   localparam int LRC_FRAME_SEL_LSB  = 0;   // frame_rate_sel_bit0..2
   localparam int LRC_P9_SEL_A_BIT   = 3;   // port_nine_func_sel_a
   localparam int LRC_P9_SEL_B_BIT   = 4;   // port_nine_func_sel_b
   localparam int LRC_CLK_SRC_BIT    = 5;   // clock_source_sel
   localparam int LRC_PORT_FUNC_LSB  = 6;   // 8 bits, 1 = port
   localparam int LRC_PORT_VAL_LSB   = 14;  // 8 bits
   localparam int LRC_P9_VAL_BIT     = 22;
   localparam int LRC_THIRD_DUTY_BIT = 23;
   localparam int LRC_KS_SEG_BIT     = 24;
   localparam int LRC_CTRL_W         = 25;
   localparam logic [LRC_CTRL_W-1:0] LRC_CTRL_RST = 25'h0000000;

   // status register fields
   localparam int LRC_ST_SYS_RST_BIT = 0;
   localparam int LRC_ST_PWR_RST_BIT = 1;
   localparam int LRC_ST_PIN_RST_BIT = 2;
   localparam int LRC_ST_CLK_RUN_BIT = 3;

   // frame divisors per select code
   localparam logic [9:0] LRC_DIV_768 = 10'h300;
   localparam logic [9:0] LRC_DIV_576 = 10'h240;
   localparam logic [9:0] LRC_DIV_384 = 10'h180;
   localparam logic [9:0] LRC_DIV_288 = 10'h120;
   localparam logic [9:0] LRC_DIV_192 = 10'h0C0;

   localparam int LRC_KEY_BITS  = 30;
   localparam int LRC_PORT_BITS = 8;

   typedef enum logic [1:0] {
      LRC_P9_SEG   = 2'b00,
      LRC_P9_GPO   = 2'b01,
      LRC_P9_CLK   = 2'b10
   } lrc_p9_mode_type;

   typedef struct packed {
      logic [9:0] cnt_r;
      logic       tick_r;
   } lrc_div_state_type;

   typedef struct packed {
      logic                     supply_detect_reset_s1_r;
      logic                     supply_detect_reset_s2_r;
      logic                     resn_s1_r;
      logic                     resn_s2_r;
      logic                     ce_s1_r;
      logic                     ce_s2_r;
      logic                     ce_d_r;
      logic                     pwr_rst_r;
      logic [LRC_CTRL_W-1:0]    ctrl_r;
      logic [31:0]              prdata_r;
      logic                     pready_r;
      logic                     pslverr_r;
      logic                     sys_rst_r;
      logic                     display_on_r;
      logic                     key_scan_en_r;
      logic                     contrast_en_r;
      logic [LRC_KEY_BITS-1:0]  key_data_r;
      logic [LRC_PORT_BITS-1:0] port_func_r;
      logic [LRC_PORT_BITS-1:0] port_val_r;
      lrc_p9_mode_type          p9_mode_r;
      logic                     p9_out_r;
      logic                     com4_common_r;
      logic                     ks_shared_seg_r;
      logic                     drv_force_low_r;
      logic                     rc_osc_en_r;
      logic                     ext_clk_acc_r;
      logic                     osc_oe_r;
      logic                     data_out_oe_r;
      logic                     latch_wr_r;
   } lrc_state_type;

   // divisor lookup used by the frame divider
   function automatic logic [9:0] lrc_frame_div(input logic [2:0] sel);
      logic [9:0] d;
      d = LRC_DIV_384;
      // sel[0] is frame_rate_sel_bit0, so codes read right to left
      case (sel)
         3'b011:  d = LRC_DIV_768;
         3'b111:  d = LRC_DIV_576;
         3'b000:  d = LRC_DIV_384;
         3'b100:  d = LRC_DIV_288;
         3'b010:  d = LRC_DIV_192;
         default: d = LRC_DIV_384;
      endcase
      return d;
   endfunction

endpackage

// ==== hdl/lrc_frame_div.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// frame rate divider
// ---------------------------------------------------------------
module lrc_frame_div
   import lrc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic [2:0] frame_sel,
   output logic            frame_tick
);

   lrc_div_state_type s_r;
   lrc_div_state_type s_nxt;

   // count internal clocks; a stopped clock holds the count at zero
   always_comb begin
      s_nxt        = s_r;
      s_nxt.tick_r = 1'b0;
      if (!run) begin
         s_nxt.cnt_r = 10'h000;
      end else if (s_r.cnt_r >= lrc_frame_div(frame_sel) - 10'h001) begin
         s_nxt.cnt_r  = 10'h000;                                 // RQ1
         s_nxt.tick_r = 1'b1;
      end else begin
         s_nxt.cnt_r = s_r.cnt_r + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign frame_tick = s_r.tick_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   frame_period_a: assert property (                             // RQ1
      frame_tick && run && $stable(frame_sel) |=> !frame_tick)
      else $error("frame tick repeated on next cycle");

   stop_no_tick_a: assert property (!run |=> !frame_tick)        // RQ9
      else $error("frame tick while clock stopped");

endmodule // lrc_frame_div

// ==== hdl/lrc_reset_clk.sv ====
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
// ---------------------------------------------------------------
// reset and clock control
// ---------------------------------------------------------------
// Functional notes
// RQ1: frame tick divides clock per select code
// RQ2: select 01 drives port nine as clk/2
// RQ3: supply detector asserts system reset
// RQ4: reset blanks display, stops scan, clears keys
// RQ5: reset forces shared pins segment/port, low
// RQ6: release re-enables display, scan, ports
// RQ7: detector reset ends at final strobe fall
// RQ8: reset pin low resets, high releases
// RQ9: clock generator stops during reset
// RQ10: display latch writes pass during reset
// RQ11: contrast adjust disabled during reset
// RQ12: scan and port logic reinitialised
// RQ13: serial side and control register unaffected
// RQ14: reset holds drivers low, forces pin functions
// RQ15: oscillator pin floats during reset
// RQ16: data-out released throughout reset
// RQ17: source select zero runs rc oscillator
// RQ18: source select one accepts external clock
// RQ19: either source alone asserts reset
module lrc_reset_clk
   import lrc_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     supply_detect_reset,
   input  wire logic                     reset_pin_n,
   input  wire logic                     ser_enable,
   input  wire logic                     xfer_all_done,
   input  wire logic                     key_read_req,
   input  wire logic [LRC_KEY_BITS-1:0]  key_data_in,
   input  wire logic                     latch_wr_in,
   output logic                          sys_reset,
   output logic                          display_on,
   output logic                          key_scan_en,
   output logic                          contrast_en,
   output logic [LRC_KEY_BITS-1:0]       key_data,
   output logic [LRC_PORT_BITS-1:0]      shared_segment_port_func,
   output logic [LRC_PORT_BITS-1:0]      shared_segment_port_pins,
   output lrc_p9_mode_type               port_nine_mode,
   output logic                          port_nine_shared_pin,
   output logic                          shared_fourth_common_func,
   output logic                          shared_key_scan_seg,
   output logic                          drivers_force_low,
   output logic                          rc_osc_en,
   output logic                          ext_clk_accept,
   output logic                          osc_pin_oe,
   output logic                          data_out_o,
   output logic                          data_out_oe,
   output logic                          latch_wr_en,
   output logic                          frame_tick
);

   lrc_state_type s_r;
   lrc_state_type s_nxt;
   logic          pin_rst;
   logic          ce_fall;
   logic          rst_now;
   logic          clk_run;
   logic          setup;
   logic          access;
   logic [LRC_CTRL_W-1:0] ctrl;

   // -------------------------------------------------------------
   // reset sources
   // -------------------------------------------------------------
   // second-stage synchroniser flops, plus the strobe delay flop ce_d_r, are looked at here
   assign pin_rst = !s_r.resn_s2_r;                              // RQ8
   assign ce_fall = s_r.ce_d_r && !s_r.ce_s2_r;
   assign rst_now = s_r.pwr_rst_r || pin_rst;                    // RQ19
   assign ctrl    = s_r.ctrl_r;
   assign clk_run = !s_r.sys_rst_r;                              // RQ9
   assign setup   = psel && !penable;
   assign access  = psel && penable && s_r.pready_r;

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      s_nxt           = s_r;
      s_nxt.supply_detect_reset_s1_r = supply_detect_reset;
      s_nxt.supply_detect_reset_s2_r = s_r.supply_detect_reset_s1_r;
      s_nxt.resn_s1_r = reset_pin_n;
      s_nxt.resn_s2_r = s_r.resn_s1_r;
      s_nxt.ce_s1_r   = ser_enable;
      s_nxt.ce_s2_r   = s_r.ce_s1_r;
      s_nxt.ce_d_r    = s_r.ce_s2_r;

      // detector set wins over the strobe release in the same cycle
      if (s_r.supply_detect_reset_s2_r) begin
         s_nxt.pwr_rst_r = 1'b1;                                 // RQ3
      end else if (ce_fall && xfer_all_done) begin
         s_nxt.pwr_rst_r = 1'b0;                                 // RQ7
      end

      // apb: zero wait states, answer in the access cycle
      s_nxt.pready_r  = setup;
      s_nxt.pslverr_r = 1'b0;
      s_nxt.prdata_r  = 32'h00000000;
      if (setup) begin
         case (paddr)
            LRC_CTRL_OFFS: begin
               s_nxt.prdata_r[LRC_CTRL_W-1:0] = s_r.ctrl_r;
            end
            LRC_STATUS_OFFS: begin
               s_nxt.prdata_r[LRC_ST_SYS_RST_BIT] = s_r.sys_rst_r;
               s_nxt.prdata_r[LRC_ST_PWR_RST_BIT] = s_r.pwr_rst_r;
               s_nxt.prdata_r[LRC_ST_PIN_RST_BIT] = pin_rst;
               s_nxt.prdata_r[LRC_ST_CLK_RUN_BIT] = clk_run;
            end
            default: begin
               s_nxt.pslverr_r = 1'b1;
            end
         endcase
      end
      // control register keeps its contents across system reset
      if (access && pwrite && paddr == LRC_CTRL_OFFS) begin
         s_nxt.ctrl_r = pwdata[LRC_CTRL_W-1:0];                  // RQ13
      end

      s_nxt.sys_rst_r = rst_now;
      s_nxt.latch_wr_r = latch_wr_in;                            // RQ10

      if (rst_now) begin
         s_nxt.display_on_r    = 1'b0;                           // RQ4
         s_nxt.key_scan_en_r   = 1'b0;                           // RQ12
         s_nxt.key_data_r      = '0;                             // RQ4
         s_nxt.contrast_en_r   = 1'b0;                           // RQ11
         s_nxt.port_func_r     = '0;                             // RQ5
         s_nxt.port_val_r      = '0;                             // RQ5
         s_nxt.p9_mode_r       = LRC_P9_GPO;                     // RQ5
         s_nxt.p9_out_r        = 1'b0;
         s_nxt.com4_common_r   = 1'b1;                           // RQ14
         s_nxt.ks_shared_seg_r = 1'b1;                           // RQ14
         s_nxt.drv_force_low_r = 1'b1;                           // RQ14
         s_nxt.rc_osc_en_r     = 1'b0;                           // RQ9
         s_nxt.ext_clk_acc_r   = 1'b0;                           // RQ9
         s_nxt.osc_oe_r        = 1'b0;                           // RQ15
         s_nxt.data_out_oe_r   = 1'b0;                           // RQ16
      end else begin
         s_nxt.display_on_r    = 1'b1;                           // RQ6
         s_nxt.key_scan_en_r   = 1'b1;                           // RQ6
         s_nxt.key_data_r      = key_data_in;
         s_nxt.contrast_en_r   = 1'b1;
         s_nxt.port_func_r     = ctrl[LRC_PORT_FUNC_LSB +: LRC_PORT_BITS];
         s_nxt.port_val_r      = ctrl[LRC_PORT_VAL_LSB +: LRC_PORT_BITS]
                                 & ctrl[LRC_PORT_FUNC_LSB +: LRC_PORT_BITS];
         s_nxt.com4_common_r   = !ctrl[LRC_THIRD_DUTY_BIT];
         s_nxt.ks_shared_seg_r = ctrl[LRC_KS_SEG_BIT];
         s_nxt.drv_force_low_r = 1'b0;
         s_nxt.rc_osc_en_r     = !ctrl[LRC_CLK_SRC_BIT];         // RQ17
         s_nxt.ext_clk_acc_r   = ctrl[LRC_CLK_SRC_BIT];          // RQ18
         // rc network sits on the pin; external mode only listens
         s_nxt.osc_oe_r        = !ctrl[LRC_CLK_SRC_BIT];
         s_nxt.data_out_oe_r   = key_read_req;
         case ({ctrl[LRC_P9_SEL_A_BIT], ctrl[LRC_P9_SEL_B_BIT]})
            2'b01: begin
               // toggle every internal clock gives half rate
               s_nxt.p9_mode_r = LRC_P9_CLK;                     // RQ2
               s_nxt.p9_out_r  = !s_r.p9_out_r;
            end
            2'b00: begin
               s_nxt.p9_mode_r = LRC_P9_SEG;
               s_nxt.p9_out_r  = 1'b0;
            end
            default: begin
               s_nxt.p9_mode_r = LRC_P9_GPO;
               s_nxt.p9_out_r  = ctrl[LRC_P9_VAL_BIT];
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   // power-up counts as a detector reset until a transfer with done set ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r                 <= '0;
         s_r.pwr_rst_r       <= 1'b1;
         s_r.sys_rst_r       <= 1'b1;
         s_r.ctrl_r          <= LRC_CTRL_RST;
         s_r.p9_mode_r       <= LRC_P9_GPO;
         s_r.com4_common_r   <= 1'b1;
         s_r.ks_shared_seg_r <= 1'b1;
         s_r.drv_force_low_r <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   lrc_frame_div u_div (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (clk_run),
      .frame_sel (ctrl[LRC_FRAME_SEL_LSB +: 3]),
      .frame_tick(frame_tick)
   );

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign prdata                    = s_r.prdata_r;
   assign pready                    = s_r.pready_r;
   assign pslverr                   = s_r.pslverr_r;
   assign sys_reset                 = s_r.sys_rst_r;
   assign display_on                = s_r.display_on_r;
   assign key_scan_en               = s_r.key_scan_en_r;
   assign contrast_en               = s_r.contrast_en_r;
   assign key_data                  = s_r.key_data_r;
   assign shared_segment_port_func  = s_r.port_func_r;
   assign shared_segment_port_pins  = s_r.port_val_r;
   assign port_nine_mode            = s_r.p9_mode_r;
   assign port_nine_shared_pin      = s_r.p9_out_r;
   assign shared_fourth_common_func = s_r.com4_common_r;
   assign shared_key_scan_seg       = s_r.ks_shared_seg_r;
   assign drivers_force_low         = s_r.drv_force_low_r;
   assign rc_osc_en                 = s_r.rc_osc_en_r;
   assign ext_clk_accept            = s_r.ext_clk_acc_r;
   assign osc_pin_oe                = s_r.osc_oe_r;
   assign data_out_o                = 1'b0;   // open drain only pulls low
   assign data_out_oe               = s_r.data_out_oe_r;
   assign latch_wr_en               = s_r.latch_wr_r;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   det_sets_rst_a: assert property (                             // RQ3
      s_r.supply_detect_reset_s2_r |-> ##2 sys_reset)
      else $error("detector did not raise system reset");

   pin_sets_rst_a: assert property (                             // RQ19
      !s_r.resn_s2_r |=> sys_reset)
      else $error("reset pin did not raise system reset");

   release_on_fall_a: assert property (                          // RQ7
      $fell(s_r.pwr_rst_r) |-> $past(ce_fall) && $past(xfer_all_done))
      else $error("detector reset left without final strobe");

   blank_in_rst_a: assert property (                             // RQ4
      sys_reset |-> !display_on && !key_scan_en && key_data == '0)
      else $error("display or scan active during reset");

   pins_in_rst_a: assert property (                              // RQ5
      sys_reset |-> shared_segment_port_func == '0
         && shared_segment_port_pins == '0
         && port_nine_mode == LRC_P9_GPO && !port_nine_shared_pin)
      else $error("shared pins not forced during reset");

   clock_stop_a: assert property (                               // RQ9
      sys_reset |-> !rc_osc_en && !ext_clk_accept && !osc_pin_oe)
      else $error("clock generator running during reset");

   do_released_a: assert property (                              // RQ16
      sys_reset && $past(key_read_req) |-> !data_out_oe)
      else $error("data out pulled low during reset");

   release_enable_a: assert property (                           // RQ6
      !sys_reset |-> display_on && key_scan_en && contrast_en)
      else $error("functions not enabled after release");

   p9_half_clk_a: assert property (                              // RQ2
      port_nine_mode == LRC_P9_CLK ##1 port_nine_mode == LRC_P9_CLK
      |-> port_nine_shared_pin != $past(port_nine_shared_pin))
      else $error("port nine clock not at half rate");

   src_select_a: assert property (                               // RQ17
      !rst_now && !ctrl[LRC_CLK_SRC_BIT] && $stable(ctrl)
      |=> rc_osc_en && !ext_clk_accept)
      else $error("wrong clock source selected");

   latch_pass_a: assert property (                               // RQ10
      latch_wr_in |=> latch_wr_en)
      else $error("latch write lost");

   ctrl_kept_a: assert property (                                // RQ13
      access && pwrite && paddr == LRC_CTRL_OFFS
      |=> s_r.ctrl_r == $past(pwdata[LRC_CTRL_W-1:0]))
      else $error("control write lost");

   pwr_release_c: cover property ($fell(s_r.pwr_rst_r));
   pin_reset_c:   cover property ($rose(pin_rst) ##[1:20] !pin_rst);
   clk_out_c:     cover property (port_nine_mode == LRC_P9_CLK);
   apb_write_c:   cover property (access && pwrite);

endmodule // lrc_reset_clk

// ==== dv/lrc_host_model.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// host side of the serial control link
// ---------------------------------------------------------------
module lrc_host_model (
   input  wire logic pclk,
   output logic      ser_enable,
   output logic      xfer_all_done,
   output logic      key_read_req,
   output logic      latch_wr_in
);
   // the link idles with the strobe low and nothing pending
   initial begin
      ser_enable    = 1'b0;
      xfer_all_done = 1'b0;
      key_read_req  = 1'b0;
      latch_wr_in   = 1'b0;
   end

   // one framed transfer; done marks the closing one of an image
   task automatic xfer(input logic done);
      @(posedge pclk);
      ser_enable    <= 1'b1;
      latch_wr_in   <= 1'b1;
      xfer_all_done <= done;
      @(posedge pclk);
      latch_wr_in <= 1'b0;
      repeat (4) @(posedge pclk);
      ser_enable <= 1'b0;
      // done is held past the synchroniser delay of the strobe fall
      repeat (8) @(posedge pclk);
      xfer_all_done <= 1'b0;
   endtask

   // key buffer request, held as a level
   task automatic key_req(input logic v);
      @(posedge pclk);
      key_read_req <= v;
   endtask
endmodule // lrc_host_model

// ==== dv/lrc_reset_clk_tb_top.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// bench for reset and clock control
// ---------------------------------------------------------------
module lrc_reset_clk_tb_top;
   import lrc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic supply_detect_reset, reset_pin_n, ser_enable, xfer_all_done;
   logic key_read_req, latch_wr_in, sys_reset, display_on, key_scan_en;
   logic contrast_en, port_nine_shared_pin, shared_fourth_common_func;
   logic shared_key_scan_seg, drivers_force_low, rc_osc_en, err, p;
   logic ext_clk_accept, osc_pin_oe, data_out_o, data_out_oe, latch_wr_en;
   logic frame_tick;
   logic [LRC_KEY_BITS-1:0]  key_data_in, key_data;
   logic [LRC_PORT_BITS-1:0] shared_segment_port_func;
   logic [LRC_PORT_BITS-1:0] shared_segment_port_pins;
   lrc_p9_mode_type          port_nine_mode;
   int num_errors, comparisons, cycles, latch_cnt, n;
   // ports 0xFF, values 0xA5, port nine value 1, port nine as clock
   localparam logic [31:0] CTRL_V = 32'h00697FD0;
   logic [2:0] codes [5] = '{3'h3, 3'h7, 3'h0, 3'h4, 3'h2};
   int         divs  [5] = '{768, 576, 384, 288, 192};

   lrc_reset_clk lrc_reset_clk_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .supply_detect_reset, .reset_pin_n, .ser_enable, .xfer_all_done,
      .key_read_req, .key_data_in, .latch_wr_in, .sys_reset, .display_on,
      .key_scan_en, .contrast_en, .key_data, .shared_segment_port_func,
      .shared_segment_port_pins, .port_nine_mode, .port_nine_shared_pin,
      .shared_fourth_common_func, .shared_key_scan_seg, .drivers_force_low,
      .rc_osc_en, .ext_clk_accept, .osc_pin_oe, .data_out_o, .data_out_oe,
      .latch_wr_en, .frame_tick);
   lrc_host_model host_i (.pclk, .ser_enable, .xfer_all_done,
      .key_read_req, .latch_wr_in);

   // ---------------------------------------------------------------
   // clock, timeout and helpers
   // ---------------------------------------------------------------
   always #2 pclk = ~pclk;

   // a hung handshake would otherwise stall the run forever
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      latch_cnt <= latch_cnt + int'(latch_wr_en === 1'b1);
      if (cycles == 30000) begin
         num_errors++;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_cyc(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask

   // cycles between two frame ticks, skipping the first partial frame
   task automatic frame_gap(output int g);
      g = 0;
      do @(posedge pclk); while (frame_tick !== 1'b1);
      do begin
         @(posedge pclk);
         g++;
      end while (frame_tick !== 1'b1);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      supply_detect_reset = 1'b0;
      reset_pin_n = 1'b1;
      key_data_in = '1;
      {num_errors, comparisons, cycles, latch_cnt} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      host_i.key_req(1'b1);
      wait_cyc(6);
      check({display_on, key_scan_en, key_data}, 32'h0);
      check({rc_osc_en, ext_clk_accept, osc_pin_oe}, 3'h0);
      check(contrast_en, 1'b0);
      check(data_out_oe, 1'b0);
      check({drivers_force_low, shared_fourth_common_func,
             shared_key_scan_seg}, 3'h7);
      check(sys_reset, 1'b1);
      $display("test power-up state done");
      // control path keeps working while the system is held
      apb(1'b1, LRC_CTRL_OFFS, CTRL_V);
      apb(1'b0, LRC_CTRL_OFFS, 32'h0);
      check(rd, CTRL_V);
      apb(1'b0, LRC_STATUS_OFFS, 32'h0);
      check(rd, 32'h3);
      apb(1'b0, 8'h08, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      wait_cyc(2);
      check({port_nine_mode, port_nine_shared_pin, shared_segment_port_func,
             shared_segment_port_pins}, {LRC_P9_GPO, 17'h0});
      $display("test register access in reset done");
      host_i.xfer(1'b0);
      check(latch_cnt, 1);
      check(sys_reset, 1'b1);
      host_i.xfer(1'b1);
      wait_cyc(1);
      check({sys_reset, display_on, key_scan_en}, 3'h3);
      check(shared_segment_port_pins, 8'hA5);
      check({rc_osc_en, ext_clk_accept}, 2'h2);
      check(port_nine_mode, LRC_P9_CLK);
      check({drivers_force_low, shared_fourth_common_func,
             shared_key_scan_seg, osc_pin_oe, contrast_en}, 5'h0B);
      check(key_data, 32'h3FFFFFFF);
      check({data_out_oe, data_out_o}, 2'h2);
      for (int i = 0; i < 2; i++) begin
         p = port_nine_shared_pin;
         wait_cyc(1);
         check(port_nine_shared_pin, !p);
      end
      $display("test release done");
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, LRC_CTRL_OFFS, CTRL_V | 32'(codes[i]));
         frame_gap(n);
         frame_gap(n);
         check(n, divs[i]);
      end
      apb(1'b1, LRC_CTRL_OFFS, CTRL_V | 32'h20);
      wait_cyc(4);
      check({rc_osc_en, ext_clk_accept}, 2'h1);
      $display("test frame rate and clock source done");
      @(posedge pclk);
      reset_pin_n <= 1'b0;
      wait_cyc(6);
      check({sys_reset, display_on}, 2'h2);
      @(posedge pclk);
      reset_pin_n <= 1'b1;
      wait_cyc(6);
      check({sys_reset, display_on}, 2'h1);
      @(posedge pclk);
      supply_detect_reset <= 1'b1;
      wait_cyc(6);
      check(sys_reset, 1'b1);
      @(posedge pclk);
      supply_detect_reset <= 1'b0;
      wait_cyc(6);
      check(sys_reset, 1'b1);
      host_i.xfer(1'b1);
      wait_cyc(1);
      check(sys_reset, 1'b0);
      $display("test pin and detector reset done");
      print_verdict();
   end
endmodule // lrc_reset_clk_tb_top
